// *** core/dtm_timer.sv ***
// dual 16-bit down-counter timer with reload, capture, toggling pin a and four
// interrupt sources on two system interrupt lines
// assumes software drives the control ports from the ref_clk domain; pins and
// the slow clock come from outside and are synchronised here
//
// Notes on behaviour
// [RULE_01] mode 4: counter one reloads from a
// [RULE_02] mode 4: pin a toggles on each underflow
// [RULE_03] rising toggle sets pending c, enable a gates
// [RULE_04] mode 4: pin b captures counter two into b
// [RULE_05] capture edge selectable rising or falling
// [RULE_06] preset stores value then forces ffff
// [RULE_07] pin b pulses last one clock period
// [RULE_08] mode 4: capture sets b, underflow two sets d
// [RULE_09] event or accumulate clock in modes 2,4 stops
// [RULE_10] software keeps counter two running in mode 4
// [RULE_11] a, b, c join irq one; d irq two
// [RULE_12] each source has pending flag and enable
// [RULE_13] mode 1: reload a/b sets a/b, d underflow
// [RULE_14] mode 2: captures a,b; underflows c,d
// [RULE_15] mode 3: reload a sets a, reload b d
// [RULE_16] toggling pin starts at initial level bit
// [RULE_17] toggling output only in modes 1, 3, 4
// [RULE_18] mode 2 pin a captures counter one, optional preset
// [RULE_19] mode 2 pin b captures counter one, optional preset
// [RULE_20] mode 4 pin b captures counter two, optional preset
// [RULE_21] prescaled clock divides by divisor plus one
// [RULE_22] clock select codes; nonzero starts counter
// [RULE_23] pending flags stay set until cleared
// [RULE_24] underflow is decrement from zero, same tick
`timescale 1ns/100ps
`include "dtm_cfg.svh"

module dtm_timer
    import dtm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire dtm_mode_t mode,
    input wire logic [4:0] prescale_divisor,
    input wire logic [2:0] counter_one_clock_select,
    input wire logic [2:0] counter_two_clock_select,
    input wire logic pin_a_function_enable,
    input wire logic pin_b_preset_enable,
    input wire logic pin_a_initial_level,
    input wire logic pin_a_capture_rising,
    input wire logic pin_b_capture_rising,
    input wire dtm_src_t irq_enable,
    input wire dtm_src_t pending_clear,
    input wire dtm_wr_t sw_write,
    input wire logic slow_clk_in,
    input wire logic timer_pin_a_in,
    output logic timer_pin_a_out,
    output logic timer_pin_a_oe,
    input wire logic timer_pin_b_in,
    output logic [`DTM_CNT_W-1:0] counter_one,
    output logic [`DTM_CNT_W-1:0] counter_two,
    output logic [`DTM_CNT_W-1:0] reload_capture_a,
    output logic [`DTM_CNT_W-1:0] reload_capture_b,
    output dtm_src_t pending,
    output logic timer_irq_1,
    output logic timer_irq_2
);

    // ********************************************************************
    // functions
    // ********************************************************************

    // valid edge of a synchronised pin: rising or falling as selected
    function automatic logic valid_edge(input logic now, input logic prev, input logic rising);
        valid_edge = rising ? (now & ~prev) : (~now & prev);
    endfunction

    // one tick of a counter clock for a given clock selection
    function automatic logic sel_tick(
        input logic [2:0] sel,
        input logic presc,
        input logic slow,
        input logic ext,
        input logic pin_level
    );
        if (sel == `DTM_CS_PRESCALED) begin
            sel_tick = presc;
        end else if (sel == `DTM_CS_SLOW) begin
            sel_tick = slow;
        end else if (sel == `DTM_CS_EXT_EVENT) begin
            sel_tick = ext;
        end else if (sel == `DTM_CS_PULSE_ACC) begin
            sel_tick = presc & pin_level;
        end else begin
            sel_tick = 1'b0;
        end
    endfunction

    function automatic logic pin_clock_sel(input logic [2:0] sel);
        pin_clock_sel = (sel == `DTM_CS_EXT_EVENT) || (sel == `DTM_CS_PULSE_ACC);
    endfunction

    // ********************************************************************
    // pin and slow clock synchronisers
    // ********************************************************************

    logic [2:0] a_sync;
    logic [2:0] b_sync;
    logic [2:0] slow_sync;
    logic [1:0] sync_age;
    // a false edge right after reset is masked until stage 2 holds a pin sample
    wire logic sync_ready = (sync_age == 2'h3);

    // stage 0 feeds stage 1 only; stage 2 is the edge reference
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            a_sync <= 3'h0;
            b_sync <= 3'h0;
            slow_sync <= 3'h0;
            sync_age <= 2'h0;
        end else begin
            a_sync <= {a_sync[1:0], timer_pin_a_in};
            b_sync <= {b_sync[1:0], timer_pin_b_in};
            slow_sync <= {slow_sync[1:0], slow_clk_in};
            if (!sync_ready) begin
                sync_age <= sync_age + 2'h1;
            end
        end
    end

    wire logic a_edge = sync_ready &&
        valid_edge(a_sync[1], a_sync[2], pin_a_capture_rising); // [RULE_05]
    wire logic b_edge = sync_ready &&
        valid_edge(b_sync[1], b_sync[2], pin_b_capture_rising); // [RULE_05]
    wire logic b_rise = sync_ready && b_sync[1] && !b_sync[2];
    wire logic slow_tick = sync_ready && slow_sync[1] && !slow_sync[2];

    // ********************************************************************
    // prescaler
    // ********************************************************************

    logic [4:0] presc_cnt;
    // a lowered divisor takes effect at once instead of running the count round
    wire logic presc_tick = (presc_cnt >= prescale_divisor); // [RULE_21]
    wire logic [4:0] next_presc_cnt = presc_tick ? `DTM_PRESCALE_RESET : presc_cnt + 5'h01;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            presc_cnt <= `DTM_PRESCALE_RESET;
        end else begin
            presc_cnt <= next_presc_cnt;
        end
    end

    // ********************************************************************
    // clock selection
    // ********************************************************************

    wire logic mode_pins_capture = (mode == DTM_DUAL_CAPTURE) || (mode == DTM_CAPTURE_TIMER);
    // a pin based clock where pin b is a capture input halts both counters
    wire logic bad_sel = mode_pins_capture &&
        (pin_clock_sel(counter_one_clock_select) || pin_clock_sel(counter_two_clock_select)); // [RULE_09]
    wire logic run_one = (counter_one_clock_select != `DTM_CS_STOP) && !bad_sel; // [RULE_22]
    wire logic run_two = (counter_two_clock_select != `DTM_CS_STOP) && !bad_sel; // [RULE_22]
    wire logic tick_one = run_one &&
        sel_tick(counter_one_clock_select, presc_tick, slow_tick, b_rise, b_sync[1]); // [RULE_22]
    wire logic tick_two = run_two &&
        sel_tick(counter_two_clock_select, presc_tick, slow_tick, b_rise, b_sync[1]); // [RULE_22]

    // ********************************************************************
    // counter one
    // ********************************************************************

    logic reload_from_b;
    logic pin_a_level;
    logic [`DTM_CNT_W-1:0] next_counter_one;
    logic [`DTM_CNT_W-1:0] next_capture_a;
    logic next_reload_from_b;
    logic next_pin_a_level;
    logic ev_a;
    logic ev_b_one;
    logic ev_c;

    wire logic under_one = tick_one && (counter_one == `DTM_CNT_RESET); // [RULE_24]
    wire logic toggle_mode = (mode != DTM_DUAL_CAPTURE) && pin_a_function_enable; // [RULE_17]
    wire logic cap_a = (mode == DTM_DUAL_CAPTURE) && a_edge;
    wire logic cap_b_one = (mode == DTM_DUAL_CAPTURE) && b_edge;

    always_comb begin
        next_counter_one = counter_one;
        next_capture_a = sw_write.reload_a ? sw_write.data : reload_capture_a;
        next_reload_from_b = reload_from_b;
        next_pin_a_level = pin_a_level;
        ev_a = 1'b0;
        ev_b_one = 1'b0;
        ev_c = 1'b0;
        case (mode)
            DTM_PWM: begin
                if (under_one) begin
                    next_counter_one = reload_from_b ? reload_capture_b : reload_capture_a;
                    next_reload_from_b = !reload_from_b;
                    ev_a = !reload_from_b; // [RULE_13]
                    ev_b_one = reload_from_b; // [RULE_13]
                end else if (tick_one) begin
                    next_counter_one = counter_one - 16'h0001;
                end
            end
            DTM_DUAL_CAPTURE: begin
                if (cap_a) begin
                    next_capture_a = counter_one; // [RULE_18]
                    ev_a = 1'b1; // [RULE_14]
                end
                ev_b_one = cap_b_one; // [RULE_14]
                ev_c = under_one; // [RULE_14]
                if ((cap_a && pin_a_function_enable) || (cap_b_one && pin_b_preset_enable)) begin
                    next_counter_one = `DTM_PRESET_VALUE; // [RULE_18] [RULE_19]
                end else if (tick_one) begin
                    next_counter_one = counter_one - 16'h0001; // wraps to ffff
                end
            end
            default: begin
                if (under_one) begin
                    next_counter_one = reload_capture_a; // [RULE_01]
                    ev_a = 1'b1; // [RULE_15]
                end else if (tick_one) begin
                    next_counter_one = counter_one - 16'h0001; // [RULE_01]
                end
            end
        endcase
        // mode 1 always restarts from register a
        if (!run_one || (mode != DTM_PWM)) begin
            next_reload_from_b = 1'b0;
        end
        if (!run_one) begin
            next_pin_a_level = pin_a_initial_level; // [RULE_16]
        end else if (under_one && toggle_mode) begin
            next_pin_a_level = !pin_a_level; // [RULE_02]
            ev_c = (mode != DTM_PWM) && !pin_a_level; // [RULE_03]
        end
        if (sw_write.counter_one) begin
            next_counter_one = sw_write.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            counter_one <= `DTM_CNT_RESET;
            reload_capture_a <= `DTM_CNT_RESET;
            reload_from_b <= 1'b0;
            pin_a_level <= 1'b0;
        end else begin
            counter_one <= next_counter_one;
            reload_capture_a <= next_capture_a;
            reload_from_b <= next_reload_from_b;
            pin_a_level <= next_pin_a_level;
        end
    end

    assign timer_pin_a_out = pin_a_level;
    assign timer_pin_a_oe = toggle_mode; // [RULE_17]

    // ********************************************************************
    // counter two
    // ********************************************************************

    logic [`DTM_CNT_W-1:0] next_counter_two;
    logic [`DTM_CNT_W-1:0] next_capture_b;
    logic ev_b_two;
    logic ev_d;

    wire logic under_two = tick_two && (counter_two == `DTM_CNT_RESET); // [RULE_24]
    wire logic cap_b_two = (mode == DTM_CAPTURE_TIMER) && b_edge; // [RULE_04]

    always_comb begin
        next_counter_two = counter_two;
        next_capture_b = sw_write.reload_b ? sw_write.data : reload_capture_b;
        ev_b_two = 1'b0;
        ev_d = under_two; // [RULE_08] [RULE_13] [RULE_14] [RULE_15]
        if (cap_b_one) begin
            next_capture_b = counter_one; // [RULE_19]
        end
        case (mode)
            DTM_DUAL_TIMER: begin
                if (under_two) begin
                    next_counter_two = reload_capture_b;
                end else if (tick_two) begin
                    next_counter_two = counter_two - 16'h0001;
                end
            end
            DTM_CAPTURE_TIMER: begin
                if (cap_b_two) begin
                    next_capture_b = counter_two; // [RULE_04] [RULE_20]
                    ev_b_two = 1'b1; // [RULE_08]
                end
                if (cap_b_two && pin_b_preset_enable) begin
                    next_counter_two = `DTM_PRESET_VALUE; // [RULE_06] [RULE_20]
                end else if (tick_two) begin
                    next_counter_two = counter_two - 16'h0001; // [RULE_04]
                end
            end
            default: begin
                if (tick_two) begin
                    next_counter_two = counter_two - 16'h0001; // wraps to ffff
                end
            end
        endcase
        if (sw_write.counter_two) begin
            next_counter_two = sw_write.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            counter_two <= `DTM_CNT_RESET;
            reload_capture_b <= `DTM_CNT_RESET;
        end else begin
            counter_two <= next_counter_two;
            reload_capture_b <= next_capture_b;
        end
    end

    // ********************************************************************
    // pending flags and system interrupts
    // ********************************************************************

    dtm_src_t pend_set;
    dtm_src_t next_pending;

    assign pend_set.a = ev_a; // [RULE_12]
    assign pend_set.b = ev_b_one | ev_b_two; // [RULE_12]
    assign pend_set.c = ev_c; // [RULE_12]
    assign pend_set.d = ev_d; // [RULE_12]
    // a set in the clearing cycle wins
    assign next_pending = (pending & ~pending_clear) | pend_set; // [RULE_23]

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pending <= `DTM_PENDING_RESET;
        end else begin
            pending <= next_pending;
        end
    end

    wire dtm_src_t active = pending & irq_enable; // [RULE_12]
    // in the timer modes the rising toggle source is gated by enable a
    wire logic timer_modes = (mode == DTM_DUAL_TIMER) || (mode == DTM_CAPTURE_TIMER);
    wire logic c_request = pending.c && (timer_modes ? irq_enable.a : irq_enable.c); // [RULE_03]
    assign timer_irq_1 = active.a | active.b | c_request; // [RULE_11]
    assign timer_irq_2 = active.d; // [RULE_11]

endmodule

// *** core/dtm_cfg.svh ***
// constants of the dual down-counter timer: encodings, presets, reset values
// assumes inclusion by the timer package and the timer core only
`ifndef DTM_CFG_SVH
`define DTM_CFG_SVH

// counter width and the value a capture preset forces
`define DTM_CNT_W 16
`define DTM_PRESET_VALUE 16'hffff

// clock select encodings
`define DTM_CS_STOP 3'h0
`define DTM_CS_PRESCALED 3'h1
`define DTM_CS_EXT_EVENT 3'h2
`define DTM_CS_PULSE_ACC 3'h3
`define DTM_CS_SLOW 3'h4

// mode encodings on the mode port
`define DTM_MODE_PWM 2'h0
`define DTM_MODE_DUAL_CAPTURE 2'h1
`define DTM_MODE_DUAL_TIMER 2'h2
`define DTM_MODE_CAPTURE_TIMER 2'h3

// reset values
`define DTM_PRESCALE_RESET 5'h00
`define DTM_CNT_RESET 16'h0000
`define DTM_PENDING_RESET 4'h0

`endif

// *** core/dtm_pkg.sv ***
// types shared by the dual down-counter timer and its surroundings
// assumes dtm_cfg.svh is on the include path
`include "dtm_cfg.svh"

package dtm_pkg;

    typedef enum logic [1:0] {
        DTM_PWM = `DTM_MODE_PWM,
        DTM_DUAL_CAPTURE = `DTM_MODE_DUAL_CAPTURE,
        DTM_DUAL_TIMER = `DTM_MODE_DUAL_TIMER,
        DTM_CAPTURE_TIMER = `DTM_MODE_CAPTURE_TIMER
    } dtm_mode_t;

    // pending flags and their enables, one bit per interrupt source
    typedef struct packed {
        logic d;
        logic c;
        logic b;
        logic a;
    } dtm_src_t;

    // software write strobes, one cycle, with their shared data word
    typedef struct packed {
        logic counter_one;
        logic counter_two;
        logic reload_a;
        logic reload_b;
        logic [`DTM_CNT_W-1:0] data;
    } dtm_wr_t;

endpackage

// *** verification/dtm_timer_props.sv ***
// assertions on the port behaviour of the dual down-counter timer
// assumes a bind onto dtm_timer, one clock, synchronous reset
`timescale 1ns/100ps
module dtm_timer_props
    import dtm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire dtm_mode_t mode,
    input wire logic [4:0] prescale_divisor,
    input wire logic [2:0] counter_one_clock_select,
    input wire logic [2:0] counter_two_clock_select,
    input wire logic pin_a_function_enable,
    input wire logic pin_b_preset_enable,
    input wire dtm_src_t irq_enable,
    input wire dtm_src_t pending_clear,
    input wire dtm_wr_t sw_write,
    input wire logic timer_pin_a_out,
    input wire logic timer_pin_a_oe,
    input wire logic [15:0] counter_one,
    input wire logic [15:0] counter_two,
    input wire logic [15:0] reload_capture_a,
    input wire logic [15:0] reload_capture_b,
    input wire dtm_src_t pending,
    input wire logic timer_irq_1,
    input wire logic timer_irq_2
);
    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire logic sel_ok = !counter_two_clock_select[1] && counter_one_clock_select == 3'h1;
    wire logic run4 = mode == DTM_CAPTURE_TIMER && sel_ok && !sw_write.counter_one;
    property p_irq;
        timer_irq_2 == (pending.d & irq_enable.d)
            && timer_irq_1 == (pending.a & irq_enable.a || pending.b & irq_enable.b
            || pending.c & (mode inside {DTM_DUAL_TIMER, DTM_CAPTURE_TIMER} ? irq_enable.a
            : irq_enable.c));
    endproperty
    a_irq: assert property (p_irq) else $error("irq lines off");
    property p_sticky;
        ##1 (($past(pending) & ~$past(pending_clear) & ~pending) == 4'h0);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_oe;
        timer_pin_a_oe == (pin_a_function_enable && mode != DTM_DUAL_CAPTURE);
    endproperty
    a_oe: assert property (p_oe) else $error("pin a drive wrong");
    property p_reload;
        run4 && $past(counter_one_clock_select) == 3'h1 && prescale_divisor == 5'h0
            && counter_one == 16'h0 && !sw_write.reload_a |=> counter_one == $past(reload_capture_a);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload");
    property p_scale;
        run4 && prescale_divisor == 5'h3 && $stable(prescale_divisor) && !$past(sw_write.counter_one)
            && counter_one == $past(counter_one) - 16'h1
            |=> $stable(counter_one)[*3] ##1 $changed(counter_one);
    endproperty
    a_scale: assert property (p_scale) else $error("tick rate wrong");
    property p_stop;
        mode == DTM_CAPTURE_TIMER && counter_one_clock_select inside {3'h2, 3'h3}
            && !sw_write.counter_one |=> $stable(counter_one);
    endproperty
    a_stop: assert property (p_stop) else $error("counter ran");
    property p_tog;
        mode == DTM_CAPTURE_TIMER && pin_a_function_enable && $past(counter_one) == 16'h0
            && counter_one == reload_capture_a && reload_capture_a != 16'h0
            && !$past(sw_write.counter_one) |-> ##[0:1] $changed(timer_pin_a_out);
    endproperty
    a_tog: assert property (p_tog) else $error("no toggle");
    property p_cap;
        mode == DTM_CAPTURE_TIMER && $stable(mode) && $changed(reload_capture_b)
            && !$past(sw_write.reload_b) && !$past(sw_write.counter_two)
            |-> pending.b && (!$past(pin_b_preset_enable) || counter_two == 16'hffff);
    endproperty
    a_cap: assert property (p_cap) else $error("capture wrong");
endmodule

bind dtm_timer dtm_timer_props u_dtm_timer_props (
    .ref_clk, .srst, .mode, .prescale_divisor, .counter_one_clock_select,
    .counter_two_clock_select, .pin_a_function_enable, .pin_b_preset_enable, .irq_enable,
    .pending_clear, .sw_write, .timer_pin_a_out, .timer_pin_a_oe, .counter_one, .counter_two,
    .reload_capture_a, .reload_capture_b, .pending, .timer_irq_1, .timer_irq_2
);

// *** verification/dtm_pin_src.sv ***
// external source on pin b and the slow clock
// assumes edge requests arrive as one-cycle pulses on ref_clk
`timescale 1ns/100ps
module dtm_pin_src (
    input wire logic ref_clk,
    input wire logic edge_req,
    output logic timer_pin_b_in,
    output logic slow_clk_in
);
    // ****************************************
    // pin drive
    // ****************************************
    logic [1:0] slow_div = 2'h0;
    logic [1:0] hold = 2'h0;
    initial timer_pin_b_in = 1'b0;
    // pin b flips on request and holds at least four clocks
    always @(posedge ref_clk) begin
        slow_div <= slow_div + 2'h1;
        if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end else if (edge_req) begin
            timer_pin_b_in <= ~timer_pin_b_in;
            hold <= 2'h3;
        end
    end
    assign slow_clk_in = slow_div[1];
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the dual timer in its capture plus timer mode
// assumes dtm_pkg and the pin source model are compiled first
`timescale 1ns/100ps
module tb_top
    import dtm_pkg::*;
;
    logic ref_clk, srst, pin_a_function_enable, pin_b_preset_enable, pin_a_initial_level;
    logic pin_b_capture_rising, edge_req, timer_pin_a_out, timer_pin_a_oe, timer_pin_b_in;
    logic slow_clk_in, timer_irq_1, timer_irq_2;
    logic [4:0] prescale_divisor;
    logic [2:0] counter_one_clock_select, counter_two_clock_select;
    logic [15:0] counter_one, counter_two, reload_capture_a, reload_capture_b, held_two;
    dtm_mode_t mode;
    dtm_src_t irq_enable, pending_clear, pending;
    dtm_wr_t sw_write;
    int fail_count, total_checks, n;
    dtm_timer u_dtm_timer (
        .ref_clk, .srst, .mode, .prescale_divisor, .counter_one_clock_select,
        .counter_two_clock_select, .pin_a_function_enable, .pin_b_preset_enable,
        .pin_a_initial_level, .pin_a_capture_rising(1'b0), .pin_b_capture_rising,
        .irq_enable, .pending_clear, .sw_write, .slow_clk_in, .timer_pin_a_in(timer_pin_a_out),
        .timer_pin_a_out, .timer_pin_a_oe, .timer_pin_b_in, .counter_one, .counter_two,
        .reload_capture_a, .reload_capture_b, .pending, .timer_irq_1, .timer_irq_2
    );
    dtm_pin_src u_dtm_pin_src (.ref_clk, .edge_req, .timer_pin_b_in, .slow_clk_in);
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic bound(input int k);
        if (k >= 200) begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    // sel is {counter one, counter two, reload a, reload b}
    task automatic wr(input logic [3:0] sel, input logic [15:0] data);
        @(posedge ref_clk);
        sw_write <= {sel, data};
        @(posedge ref_clk);
        sw_write <= '0;
        #1;
    endtask
    task automatic half_period(input int exp);
        logic lvl;
        int k;
        #1;
        for (int i = 0; i < 2; i++) begin
            lvl = timer_pin_a_out;
            for (k = 0; k < 200 && timer_pin_a_out === lvl; k++) cyc(1);
            bound(k);
        end
        check(16'(k), 16'(exp));
    endtask
    task automatic cap_edge(input logic hit);
        logic [15:0] prev;
        logic [15:0] held;
        int k;
        @(posedge ref_clk);
        edge_req <= 1'b1;
        @(posedge ref_clk);
        edge_req <= 1'b0;
        #1;
        held = reload_capture_b;
        for (k = 0; k < 8 && reload_capture_b === held; k++) begin
            prev = counter_two;
            cyc(1);
        end
        check(16'(k < 8), 16'(hit));
        check(16'(pending.b), 16'(hit));
        if (hit) begin
            check(reload_capture_b, prev);
            check(16'(counter_two == 16'hffff), 16'(pin_b_preset_enable));
        end
        @(posedge ref_clk);
        pending_clear <= 4'h2;
        @(posedge ref_clk);
        pending_clear <= 4'h0;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        srst = 1'b1;
        mode = DTM_CAPTURE_TIMER;
        prescale_divisor = 5'h00;
        counter_one_clock_select = 3'h0;
        counter_two_clock_select = 3'h0;
        pin_a_function_enable = 1'b1;
        pin_b_preset_enable = 1'b0;
        pin_a_initial_level = 1'b1;
        pin_b_capture_rising = 1'b1;
        irq_enable = 4'hf;
        pending_clear = 4'h0;
        sw_write = '0;
        edge_req = 1'b0;
        fail_count = 0;
        total_checks = 0;
        cyc(20);
        check(counter_one | counter_two | reload_capture_a | reload_capture_b, 16'h0);
        check(16'({pending, timer_irq_1, timer_irq_2}), 16'h0);
        @(posedge ref_clk);
        srst <= 1'b0;
        counter_two_clock_select <= 3'h1;
        for (n = 1; n >= 0; n--) begin
            @(posedge ref_clk);
            pin_a_initial_level <= n[0];
            cyc(3);
            check(16'(timer_pin_a_out), 16'(n));
        end
        for (n = 0; n < 4; n++) begin
            @(posedge ref_clk);
            mode <= dtm_mode_t'(n[1:0]);
            cyc(1);
            check(16'(timer_pin_a_oe), 16'(n != 1));
        end
        for (n = 0; n < 2; n++) begin
            wr(4'h2, 16'(3 - n));
            @(posedge ref_clk);
            prescale_divisor <= 5'(3 * n);
            counter_one_clock_select <= 3'h1;
            half_period((4 - n) * (3 * n + 1));
        end
        @(posedge ref_clk);
        counter_one_clock_select <= 3'h4;
        half_period(12);
        check(16'(pending), 16'hd);
        check(16'({timer_irq_1, timer_irq_2}), 16'h3);
        @(posedge ref_clk);
        counter_one_clock_select <= 3'h0;
        irq_enable <= 4'hc;
        cyc(3);
        check(16'({timer_irq_1, timer_irq_2, pending}), 16'h1d);
        @(posedge ref_clk);
        pending_clear <= 4'hf;
        @(posedge ref_clk);
        pending_clear <= 4'h0;
        irq_enable <= 4'hf;
        cyc(1);
        check(16'(pending), 16'h0);
        for (n = 2; n < 4; n++) begin
            wr(4'h8, 16'h0005);
            @(posedge ref_clk);
            counter_one_clock_select <= 3'(n);
            cyc(1);
            held_two = counter_two;
            cyc(5);
            check(counter_one, 16'h0005);
            check(counter_two, held_two);
        end
        @(posedge ref_clk);
        counter_one_clock_select <= 3'h0;
        for (n = 0; n < 4; n++) begin
            @(posedge ref_clk);
            pin_b_capture_rising <= (n < 2);
            pin_b_preset_enable <= n[1];
            cap_edge(n == 0 || n == 3);
        end
        wr(4'h4, 16'h0002);
        for (n = 0; n < 200 && pending.d !== 1'b1; n++) cyc(1);
        bound(n);
        check(16'({timer_irq_1, timer_irq_2}), 16'h1);
        give_verdict();
    end
endmodule
